// ===== core/ssd_decoder.sv
`timescale 1ns/10ps
`include "ssd_regs.svh"

// Functional notes
// - D0/D1 with reg 111 is arithmetic right shift by one, reg or memory.
// - D2/D3 with reg 111 shifts right arithmetically by count register low.
// - C0/C1 with reg 111 shifts by one immediate byte after addressing.
// - 18/19 is borrow-subtract to r/m (memory unless mod 11); 1A/1B to register; ModRM follows.
// - 80-83 with reg 011 subtracts immediate with borrow; immediate follows.
// - 1C/1D accumulator borrow-subtract; no ModRM, immediate follows opcode.
// - AE/AF is string scan; low bit selects width; no ModRM.
// - 0F 92 with reg 000 sets byte if below (carry).
// - 0F 96 with reg 000 sets byte if below or equal.
// - 0F 94 with reg 000 sets byte if equal (zero).

module ssd_decoder
  import ssd_pkg::*;
(
  CLK,
  RSTN,
  BYTE_VALID,
  BYTE_IN,
  BYTE_READY,
  FLAGS,
  DEC_VALID,
  DEC_OUT,
  SET_VALID,
  SET_BYTE,
  FLAGS_WRITE
);
  input  wire logic        CLK;
  input  wire logic        RSTN;
  input  wire logic        BYTE_VALID;
  input  wire logic [7:0]  BYTE_IN;
  output logic             BYTE_READY;
  input  wire ssd_flags_t  FLAGS;
  output logic             DEC_VALID;
  output ssd_decode_t      DEC_OUT;
  output logic             SET_VALID;
  output logic [7:0]       SET_BYTE;
  output logic             FLAGS_WRITE;

  ssd_state_t  state_r;
  ssd_state_t  state_nxt;
  ssd_decode_t pend_r;
  ssd_decode_t pend_nxt;
  ssd_decode_t out_r;
  ssd_decode_t out_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic        take;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic match7(input logic [7:0] b, input logic [7:0] pat);
    match7 = (b[7:1] == pat[7:1]);
  endfunction

  function automatic ssd_decode_t blank();
    ssd_decode_t d;
    d    = '0;
    d.op = SSD_OP_NONE;
    blank = d;
  endfunction

  // ****************************************************************
  // decode state machine
  // ****************************************************************
  assign take = BYTE_VALID;

  always_comb begin
    ssd_decode_t d;
    d         = blank();
    state_nxt = state_r;
    pend_nxt  = pend_r;
    out_nxt   = out_r;
    valid_nxt = 1'b0;
    if (take) begin
      case (state_r)
        SSD_ST_OPCODE: begin
          d.wide = BYTE_IN[0];
          if (match7(BYTE_IN, `SSD_OP_SHIFT_ONE) || match7(BYTE_IN, `SSD_OP_SHIFT_CNT)
              || match7(BYTE_IN, `SSD_OP_SHIFT_IMM)) begin
            d.has_modrm     = 1'b1;
            d.op            = match7(BYTE_IN, `SSD_OP_SHIFT_ONE) ? SSD_OP_ARSH_ONE :
                              match7(BYTE_IN, `SSD_OP_SHIFT_CNT) ? SSD_OP_ARSH_COUNT :
                              SSD_OP_ARSH_IMM;
            d.use_count_low = match7(BYTE_IN, `SSD_OP_SHIFT_CNT);
            d.imm_byte      = match7(BYTE_IN, `SSD_OP_SHIFT_IMM);
            pend_nxt        = d;
            state_nxt       = SSD_ST_MODRM;
          end else if (match7(BYTE_IN, `SSD_OP_SUBB_TO_RM)
                       || match7(BYTE_IN, `SSD_OP_SUBB_TO_REG)) begin
            d.has_modrm = 1'b1;
            d.op        = match7(BYTE_IN, `SSD_OP_SUBB_TO_RM) ? SSD_OP_SUBB_RM
                                                               : SSD_OP_SUBB_REG;
            pend_nxt    = d;
            state_nxt   = SSD_ST_MODRM;
          end else if (BYTE_IN[7:2] == 6'(`SSD_OP_GRP_IMM >> 2)) begin
            d.has_modrm    = 1'b1;
            d.op           = SSD_OP_SUBB_IMM;
            d.imm_sign_ext = BYTE_IN[1] & BYTE_IN[0];
            d.imm_byte     = ~BYTE_IN[0] | BYTE_IN[1];
            d.imm_full     = BYTE_IN[0] & ~BYTE_IN[1];
            pend_nxt       = d;
            state_nxt      = SSD_ST_MODRM;
          end else if (match7(BYTE_IN, `SSD_OP_SUBB_ACC)) begin
            d.op        = SSD_OP_SUBB_ACC;
            d.imm_byte  = ~BYTE_IN[0];
            d.imm_full  = BYTE_IN[0];
            out_nxt     = d;
            valid_nxt   = 1'b1;
          end else if (match7(BYTE_IN, `SSD_OP_SCAN)) begin
            d.op      = SSD_OP_SCAN;
            out_nxt   = d;
            valid_nxt = 1'b1;
          end else if (BYTE_IN == `SSD_OP_ESCAPE) begin
            state_nxt = SSD_ST_ESCAPE;
          end else begin
            d.illegal = 1'b1;
            out_nxt   = d;
            valid_nxt = 1'b1;
          end
        end
        SSD_ST_ESCAPE: begin
          d.has_modrm = 1'b1;
          d.is_setcc  = 1'b1;
          if (BYTE_IN == `SSD_OP2_SET_BELOW) begin
            d.op = SSD_OP_SET_B;
          end else if (BYTE_IN == `SSD_OP2_SET_BELOW_EQ) begin
            d.op = SSD_OP_SET_BE;
          end else if (BYTE_IN == `SSD_OP2_SET_EQUAL) begin
            d.op = SSD_OP_SET_E;
          end else begin
            d.illegal = 1'b1;
          end
          if (d.illegal) begin
            out_nxt   = d;
            valid_nxt = 1'b1;
            state_nxt = SSD_ST_OPCODE;
          end else begin
            pend_nxt  = d;
            state_nxt = SSD_ST_MODRM;
          end
        end
        SSD_ST_MODRM: begin
          d             = pend_r;
          d.mod_field   = BYTE_IN[7:6];
          d.reg_field   = BYTE_IN[5:3];
          d.rm_field    = BYTE_IN[2:0];
          d.dest_is_mem = (BYTE_IN[7:6] != `SSD_MOD_REGISTER)
                          && (pend_r.op != SSD_OP_SUBB_REG);
          case (pend_r.op)
            SSD_OP_ARSH_ONE, SSD_OP_ARSH_COUNT, SSD_OP_ARSH_IMM:
              d.illegal = (BYTE_IN[5:3] != `SSD_REG_SHIFT_ARITH);
            SSD_OP_SUBB_IMM:
              d.illegal = (BYTE_IN[5:3] != `SSD_REG_SUBB);
            SSD_OP_SET_B, SSD_OP_SET_BE, SSD_OP_SET_E:
              d.illegal = (BYTE_IN[5:3] != `SSD_REG_SETCC);
            default:
              d.illegal = 1'b0;
          endcase
          out_nxt   = d;
          valid_nxt = 1'b1;
          state_nxt = SSD_ST_OPCODE;
        end
        default: begin
          state_nxt = SSD_ST_OPCODE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= SSD_ST_OPCODE;
      pend_r  <= '0;
      out_r   <= '0;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      out_r   <= out_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ****************************************************************
  // set-byte result path
  // ****************************************************************
  ssd_setcc u_setcc (
    .clk          (CLK),
    .rstn         (RSTN),
    .op           (out_r.op),
    .fire         (valid_r & ~out_r.illegal),
    .flags        (FLAGS),
    .result_valid (SET_VALID),
    .result_byte  (SET_BYTE)
  );

  assign BYTE_READY = 1'b1;
  assign DEC_VALID  = valid_r;
  assign DEC_OUT    = out_r;
  assign FLAGS_WRITE = valid_r & ~out_r.illegal & ~out_r.is_setcc & (out_r.op != SSD_OP_NONE);

endmodule

// ===== core/ssd_regs.svh
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// ****************************************************************
// opcode and field patterns (D0/D2/C0/18/1A/1C/AE match upper 7 bits, 80 upper 6 bits, 0F and 0F second bytes whole byte)
// ****************************************************************
`define SSD_OP_SHIFT_ONE      8'hD0
`define SSD_OP_SHIFT_CNT      8'hD2
`define SSD_OP_SHIFT_IMM      8'hC0
`define SSD_OP_SUBB_TO_RM     8'h18
`define SSD_OP_SUBB_TO_REG    8'h1A
`define SSD_OP_SUBB_ACC       8'h1C
`define SSD_OP_GRP_IMM        8'h80
`define SSD_OP_SCAN           8'hAE
`define SSD_OP_ESCAPE         8'h0F
`define SSD_OP2_SET_BELOW     8'h92
`define SSD_OP2_SET_EQUAL     8'h94
`define SSD_OP2_SET_BELOW_EQ  8'h96
`define SSD_REG_SHIFT_ARITH   3'h7
`define SSD_REG_SUBB          3'h3
`define SSD_REG_SETCC         3'h0
`define SSD_MOD_REGISTER      2'h3

`endif

// ===== core/ssd_pkg.sv
package ssd_pkg;

  typedef enum logic [3:0] {
    SSD_OP_NONE      = 4'h0,
    SSD_OP_ARSH_ONE   = 4'h1,
    SSD_OP_ARSH_COUNT = 4'h2,
    SSD_OP_ARSH_IMM   = 4'h3,
    SSD_OP_SUBB_RM    = 4'h4,
    SSD_OP_SUBB_REG   = 4'h5,
    SSD_OP_SUBB_IMM   = 4'h6,
    SSD_OP_SUBB_ACC   = 4'h7,
    SSD_OP_SCAN      = 4'h8,
    SSD_OP_SET_B     = 4'h9,
    SSD_OP_SET_BE    = 4'hA,
    SSD_OP_SET_E     = 4'hB
  } ssd_op_t;

  typedef enum logic [1:0] {
    SSD_ST_OPCODE = 2'b00,
    SSD_ST_ESCAPE = 2'b01,
    SSD_ST_MODRM  = 2'b11
  } ssd_state_t;

  typedef struct packed {
    ssd_op_t    op;
    logic       wide;
    logic       has_modrm;
    logic [1:0] mod_field;
    logic [2:0] reg_field;
    logic [2:0] rm_field;
    logic       dest_is_mem;
    logic       use_count_low;
    logic       imm_byte;
    logic       imm_sign_ext;
    logic       imm_full;
    logic       is_setcc;
    logic       illegal;
  } ssd_decode_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } ssd_flags_t;

endpackage

// ===== core/ssd_setcc.sv
`timescale 1ns/10ps
`include "ssd_regs.svh"

module ssd_setcc
  import ssd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire ssd_op_t    op,
  input  wire logic       fire,
  input  wire ssd_flags_t flags,
  output logic            result_valid,
  output logic [7:0]      result_byte
);

  logic       valid_r;
  logic       valid_nxt;
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;
  logic       cond;

  // ****************************************************************
  // condition evaluation
  // ****************************************************************
  // one or zero
  always_comb begin
    cond = 1'b0;
    case (op)
      SSD_OP_SET_B:  cond = flags.carry;
      SSD_OP_SET_BE: cond = flags.carry | flags.zero;
      SSD_OP_SET_E:  cond = flags.zero;
      default:       cond = 1'b0;
    endcase
    valid_nxt = fire && (op == SSD_OP_SET_B || op == SSD_OP_SET_BE || op == SSD_OP_SET_E);
    byte_nxt  = valid_nxt ? {7'h00, cond} : byte_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      valid_r <= 1'b0;
      byte_r  <= 8'h00;
    end else begin
      valid_r <= valid_nxt;
      byte_r  <= byte_nxt;
    end
  end

  assign result_valid = valid_r;
  assign result_byte  = byte_r;

endmodule

// ===== test/ssd_decoder_checker.sv
`timescale 1ns/10ps
module ssd_decoder_checker
  import ssd_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        BYTE_READY,
  input wire ssd_flags_t  FLAGS,
  input wire logic        DEC_VALID,
  input wire ssd_decode_t DEC_OUT,
  input wire logic        SET_VALID,
  input wire logic [7:0]  SET_BYTE,
  input wire logic        FLAGS_WRITE
);
  // ****
  // decode and set-byte timing
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic ok;
  logic st;
  assign ok = DEC_VALID && !DEC_OUT.illegal;
  assign st = ok && DEC_OUT.is_setcc;
  a_set_follows: assert property (st |=> SET_VALID) else $error("set late");
  a_set_cause: assert property (SET_VALID |-> $past(st)) else $error("set stray");
  a_below_value: assert property (st && DEC_OUT.op == SSD_OP_SET_B |=>
    SET_BYTE == {7'h00, $past(FLAGS.carry)}) else $error("below byte");
  a_below_eq_val: assert property (st && DEC_OUT.op == SSD_OP_SET_BE |=>
    SET_BYTE == {7'h00, $past(FLAGS.carry | FLAGS.zero)}) else $error("be byte");
  a_equal_value: assert property (st && DEC_OUT.op == SSD_OP_SET_E |=>
    SET_BYTE == {7'h00, $past(FLAGS.zero)}) else $error("eq byte");
  a_flags_kept: assert property (DEC_VALID |->
    FLAGS_WRITE == !(DEC_OUT.is_setcc || DEC_OUT.illegal)) else $error("flag write");
  a_shift_reg: assert property (ok && DEC_OUT.op inside {SSD_OP_ARSH_ONE,
    SSD_OP_ARSH_COUNT, SSD_OP_ARSH_IMM} |-> DEC_OUT.reg_field == 3'h7) else $error("shift reg");
  a_count_low: assert property (ok |->
    DEC_OUT.use_count_low == (DEC_OUT.op == SSD_OP_ARSH_COUNT)) else $error("count low");
  a_imm_count: assert property (ok && DEC_OUT.op == SSD_OP_ARSH_IMM |->
    DEC_OUT.imm_byte && !DEC_OUT.imm_full) else $error("shift imm");
  a_no_modrm: assert property (ok && DEC_OUT.op inside {SSD_OP_SUBB_ACC, SSD_OP_SCAN}
    |-> !DEC_OUT.has_modrm) else $error("modrm");
  a_mem_dest: assert property (ok && DEC_OUT.has_modrm |->
    DEC_OUT.dest_is_mem == (DEC_OUT.mod_field != 2'h3 && DEC_OUT.op != SSD_OP_SUBB_REG))
    else $error("mem dest");
  c_set_one: cover property (st ##1 SET_BYTE == 8'h01);
  c_illegal: cover property (DEC_VALID && DEC_OUT.illegal);
  c_scan: cover property (ok && DEC_OUT.op == SSD_OP_SCAN);
endmodule
bind ssd_decoder ssd_decoder_checker u_chk (.CLK, .RSTN, .BYTE_READY, .FLAGS, .DEC_VALID,
  .DEC_OUT, .SET_VALID, .SET_BYTE, .FLAGS_WRITE);

// ===== test/ssd_fetch_model.sv
`timescale 1ns/10ps
module ssd_fetch_model (
  input wire logic   CLK,
  input wire logic   RSTN,
  output logic       BYTE_VALID,
  output logic [7:0] BYTE_IN
);
  // ****
  // byte queue; idle data toggles so stale bytes never look valid
  // ****
  logic [7:0] q[$];
  int         gap = 0;
  int         idle = 0;
  initial begin
    BYTE_VALID = 1'b0;
    BYTE_IN = 8'h5A;
  end
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  always @(posedge CLK) begin
    if (RSTN && q.size() != 0 && idle >= gap) begin
      BYTE_VALID <= 1'b1;
      BYTE_IN <= q.pop_front();
      idle <= 0;
    end else begin
      BYTE_VALID <= 1'b0;
      BYTE_IN <= ~BYTE_IN;
      idle <= idle + 1;
    end
  end
endmodule

// ===== test/ssd_decoder_tb.sv
`timescale 1ns/10ps
module ssd_decoder_tb
  import ssd_pkg::*;
;
  logic        CLK;
  logic        RSTN;
  logic        BYTE_VALID;
  logic [7:0]  BYTE_IN;
  logic        BYTE_READY;
  ssd_flags_t  FLAGS;
  logic        DEC_VALID;
  ssd_decode_t DEC_OUT;
  logic        SET_VALID;
  logic [7:0]  SET_BYTE;
  logic        FLAGS_WRITE;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  ssd_fetch_model fetch (.CLK, .RSTN, .BYTE_VALID, .BYTE_IN);
  ssd_decoder dut (.CLK, .RSTN, .BYTE_VALID, .BYTE_IN, .BYTE_READY, .FLAGS, .DEC_VALID,
    .DEC_OUT, .SET_VALID, .SET_BYTE, .FLAGS_WRITE);
  // ****
  // compares and shared instruction run
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic run(input int n, input logic [7:0] b0, b1, b2, input ssd_op_t op,
                     input logic w, input logic ill);
    logic [7:0] m;
    int         i;
    m = (n == 2) ? b1 : b2;
    i = 0;
    fetch.put(b0);
    if (n > 1) fetch.put(b1);
    if (n > 2) fetch.put(b2);
    do begin
      @(posedge CLK);
      #1;
      i++;
    end while (DEC_VALID !== 1'b1 && i < 12);
    chk("dec_valid", 8'h01, {7'h00, DEC_VALID});
    chk("illegal", {7'h00, ill}, {7'h00, DEC_OUT.illegal});
    chk("flags_wr", {7'h00, !ill && !(op inside {SSD_OP_SET_B, SSD_OP_SET_BE, SSD_OP_SET_E})},
        {7'h00, FLAGS_WRITE});
    if (!ill) begin
      chk("op", {4'h0, op}, {4'h0, DEC_OUT.op});
      chk("wide", {7'h00, w}, {7'h00, DEC_OUT.wide});
      chk("has_modrm", {7'h00, n > 1}, {7'h00, DEC_OUT.has_modrm});
      if (n > 1) chk("mem", {7'h00, m[7:6] != 2'h3 && op != SSD_OP_SUBB_REG},
                     {7'h00, DEC_OUT.dest_is_mem});
    end
  endtask
  task automatic t_shift();
    fetch.gap = 1;
    run(2, 8'hD0, 8'hF8, 8'h00, SSD_OP_ARSH_ONE, 1'b0, 1'b0);
    fetch.gap = 0;
    run(2, 8'hD3, 8'h3F, 8'h00, SSD_OP_ARSH_COUNT, 1'b1, 1'b0);
    chk("count_low", 8'h01, {7'h00, DEC_OUT.use_count_low});
    run(2, 8'hC1, 8'h78, 8'h00, SSD_OP_ARSH_IMM, 1'b1, 1'b0);
    chk("imm_byte", 8'h01, {7'h00, DEC_OUT.imm_byte});
    run(2, 8'hD1, 8'hE0, 8'h00, SSD_OP_NONE, 1'b0, 1'b1);
  endtask
  task automatic t_subb();
    run(2, 8'h18, 8'hC1, 8'h00, SSD_OP_SUBB_RM, 1'b0, 1'b0);
    run(2, 8'h1B, 8'h45, 8'h00, SSD_OP_SUBB_REG, 1'b1, 1'b0);
    run(2, 8'h81, 8'h1E, 8'h00, SSD_OP_SUBB_IMM, 1'b1, 1'b0);
    chk("imm_full", 8'h01, {7'h00, DEC_OUT.imm_full});
    run(2, 8'h83, 8'hDB, 8'h00, SSD_OP_SUBB_IMM, 1'b1, 1'b0);
    chk("sign_ext", 8'h01, {7'h00, DEC_OUT.imm_sign_ext});
    run(2, 8'h80, 8'hC0, 8'h00, SSD_OP_NONE, 1'b0, 1'b1);
    run(1, 8'h1D, 8'h00, 8'h00, SSD_OP_SUBB_ACC, 1'b1, 1'b0);
    run(1, 8'hAE, 8'h00, 8'h00, SSD_OP_SCAN, 1'b0, 1'b0);
    run(1, 8'hAF, 8'h00, 8'h00, SSD_OP_SCAN, 1'b1, 1'b0);
  endtask
  task automatic t_setcc();
    logic [7:0] c[3] = '{8'h92, 8'h94, 8'h96};
    ssd_op_t    o[3] = '{SSD_OP_SET_B, SSD_OP_SET_E, SSD_OP_SET_BE};
    logic       e;
    for (int k = 0; k < 3; k++) begin
      for (int f = 0; f < 4; f++) begin
        e = (k == 0) ? f[1] : (k == 1) ? f[0] : (f != 0);
        @(posedge CLK);
        FLAGS <= f[1:0];
        run(3, 8'h0F, c[k], 8'hC0 ^ {f[1:0], 6'h00}, o[k], 1'b0, 1'b0);
        @(posedge CLK);
        #1;
        chk("set_valid", 8'h01, {7'h00, SET_VALID});
        chk("set_byte", {7'h00, e}, SET_BYTE);
      end
    end
    run(3, 8'h0F, 8'h94, 8'hC8, SSD_OP_NONE, 1'b0, 1'b1);
    @(posedge CLK);
    #1;
    chk("set_valid", 8'h00, {7'h00, SET_VALID});
    run(2, 8'h0F, 8'h93, 8'h00, SSD_OP_NONE, 1'b0, 1'b1);
  endtask
  // reset lands while an escape byte is pending; the next byte must decode from scratch
  task automatic t_reset();
    fetch.put(8'h0F);
    repeat (2) @(posedge CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    #1;
    chk("rst_dec_valid", 8'h00, {7'h00, DEC_VALID});
    chk("rst_set_valid", 8'h00, {7'h00, SET_VALID});
    chk("rst_set_byte", 8'h00, SET_BYTE);
    chk("byte_ready", 8'h01, {7'h00, BYTE_READY});
    run(1, 8'hAE, 8'h00, 8'h00, SSD_OP_SCAN, 1'b0, 1'b0);
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      results();
    end
  end
  initial begin
    RSTN = 1'b0;
    FLAGS = '0;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    t_shift();
    t_subb();
    t_setcc();
    t_reset();
    results();
  end
endmodule
